//--- prx_pkg.sv
// Shared types and constants for the packet port receive interface
package prx_pkg;

   // Interface mode chosen by strap or configuration logic
   typedef enum logic [1:0] {
      PRX_MODE_MII = 2'h0,
      PRX_MODE_RMII = 2'h1,
      PRX_MODE_GMII = 2'h2,
      PRX_MODE_TEN_BIT = 2'h3
   } prx_mode_e;

   // Frame tracking states, Gray along idle to receive
   typedef enum logic [1:0] {
      PRX_ST_IDLE = 2'h0,
      PRX_ST_RECV = 2'h1
   } prx_state_e;

   // Widths of the pin bus and of one captured word, and the number of lanes
   localparam int PRX_BUS_W = 8;
   localparam int PRX_WORD_W = 10;
   localparam int PRX_LANES = 4;

   // Captured word layout: {error or bit 9, valid or bit 8, data}
   localparam int PRX_VALID_BIT = 8;
   localparam int PRX_ERROR_BIT = 9;

   // Lane index of each link clock
   localparam int PRX_LANE_RX = 0;
   localparam int PRX_LANE_REF = 1;
   localparam int PRX_LANE_TBA = 2;
   localparam int PRX_LANE_TBB = 3;

   // Units per assembled byte, counted from zero
   localparam logic [1:0] PRX_MII_LAST = 2'h1;
   localparam logic [1:0] PRX_RMII_LAST = 2'h3;

   // Data patterns that mark a false carrier with error and no valid
   localparam logic [3:0] PRX_FC_NIBBLE = 4'hE;
   localparam logic [7:0] PRX_FC_BYTE = 8'h0E;

   // Reset values
   localparam logic [9:0] PRX_WORD_RST = 10'h000;
   localparam logic [1:0] PRX_COUNT_RST = 2'h0;

endpackage

//--- prx_lane_capture.sv
// One link-clock capture lane with toggle hand-off to the core clock
`timescale 1ns/1ps
module prx_lane_capture (
   input wire logic laneClock,
   input wire logic reset_n,
   input wire logic [7:0] pinBus,
   input wire logic pinValid,
   input wire logic pinError,
   output logic [9:0] captureWord,
   output logic captureToggle
);

   typedef struct packed {
      logic rst1;
      logic rst2;
      logic [9:0] word;
      logic toggle;
   } prx_lane_s;

   prx_lane_s st;
   prx_lane_s next_st;

   // Word is held until the next edge, so the core may read it after
   // it sees the toggle; the lane clock may stop between frames
   always_comb begin
      next_st = st;
      next_st.rst1 = reset_n;
      next_st.rst2 = st.rst1;
      if (!st.rst2) begin
         next_st.word = prx_pkg::PRX_WORD_RST;
         next_st.toggle = 1'b0;
      end else begin
         next_st.word = {pinError, pinValid, pinBus};
         next_st.toggle = ~st.toggle;
      end
   end

   // Every rising edge of the lane clock captures one word once the synchronised reset is released; before that it loads the reset word
   always_ff @(posedge laneClock) begin
      st <= next_st;
   end

   assign captureWord = st.word;
   assign captureToggle = st.toggle;

endmodule

//--- prx_receive_port.sv
// Receive side of one packet port: MII, RMII, GMII and ten-bit capture
`timescale 1ns/1ps
module prx_receive_port (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire prx_pkg::prx_mode_e rxMode,
   input wire logic fullDuplex,
   input wire logic portReceiveClock,
   input wire logic portReferenceClock,
   input wire logic tbiByteClockA,
   input wire logic tbiByteClockB,
   input wire logic [7:0] portReceiveBus,
   input wire logic portReceiveValid,
   input wire logic portReceiveError,
   input wire logic portCollisionIn,
   output logic [7:0] rxData,
   output logic rxDataValid,
   output logic rxDataError,
   output logic rxFrameEnd,
   output logic rxFalseCarrier,
   output logic [9:0] rxCodeGroup,
   output logic rxCodeValid,
   output logic rxCollision,
   output logic rxInFrame
);

   typedef struct packed {
      logic [3:0] tog1;
      logic [3:0] tog2;
      logic [3:0] tog3;
      logic col1;
      logic col2;
      logic pendB;
      logic [9:0] pendWord;
      logic [7:0] shift;
      logic [1:0] count;
      logic errSticky;
      prx_pkg::prx_state_e state;
      logic [7:0] data;
      logic valid;
      logic error;
      logic frameEnd;
      logic falseCarrier;
      logic [9:0] code;
      logic codeValid;
      logic collision;
   } prx_core_s;

   prx_core_s st;
   prx_core_s next_st;

   logic [3:0] laneClock;
   logic [3:0] laneToggle;
   logic [9:0] laneWord [4];
   logic [3:0] laneEdge;
   logic take;
   logic pendSet;
   logic [9:0] word;
   logic wordValid;
   logic wordError;

   // Lane order matches the lane index constants
   assign laneClock = {tbiByteClockB, tbiByteClockA, portReferenceClock,
                       portReceiveClock};

   // One capture lane per link clock; the valid pin doubles as carrier
   // valid in RMII and as code bit 8 in ten-bit mode
   genvar gi;
   generate
      for (gi = 0; gi < prx_pkg::PRX_LANES; gi++) begin : g_lane
         prx_lane_capture u_lane (
            .laneClock(laneClock[gi]),
            .reset_n(reset_n),
            .pinBus(portReceiveBus),
            .pinValid(portReceiveValid),
            .pinError(portReceiveError),
            .captureWord(laneWord[gi]),
            .captureToggle(laneToggle[gi])
         );
      end
   endgenerate

   // Edge of a synchronised toggle; only the second and third stages
   assign laneEdge = st.tog2 ^ st.tog3;

   // Pick the word of the active lane this cycle
   always_comb begin
      take = 1'b0;
      pendSet = 1'b0;
      word = prx_pkg::PRX_WORD_RST;
      if (rxMode == prx_pkg::PRX_MODE_TEN_BIT) begin
         // alternate byte clocks
         // A word held back from the B clock goes first; both clocks in
         // one cycle are ordered A then B
         if (st.pendB) begin
            take = 1'b1;
            word = st.pendWord;
         end else if (laneEdge[prx_pkg::PRX_LANE_TBA]) begin
            take = 1'b1;
            word = laneWord[prx_pkg::PRX_LANE_TBA];
            pendSet = laneEdge[prx_pkg::PRX_LANE_TBB];
         end else if (laneEdge[prx_pkg::PRX_LANE_TBB]) begin
            take = 1'b1;
            word = laneWord[prx_pkg::PRX_LANE_TBB];
         end
      end else if (rxMode == prx_pkg::PRX_MODE_RMII) begin
         take = laneEdge[prx_pkg::PRX_LANE_REF];
         word = laneWord[prx_pkg::PRX_LANE_REF];
      end else begin
         take = laneEdge[prx_pkg::PRX_LANE_RX];
         word = laneWord[prx_pkg::PRX_LANE_RX];
      end
   end

   assign wordValid = word[prx_pkg::PRX_VALID_BIT];
   assign wordError = word[prx_pkg::PRX_ERROR_BIT];

   // Next state: synchronisers, assembly, frame tracking
   always_comb begin
      next_st = st;
      next_st.tog1 = laneToggle;
      next_st.tog2 = st.tog1;
      next_st.tog3 = st.tog2;
      next_st.col1 = portCollisionIn;
      next_st.col2 = st.col1;
      next_st.collision = st.col2 & ~fullDuplex;
      next_st.valid = 1'b0;
      next_st.frameEnd = 1'b0;
      next_st.falseCarrier = 1'b0;
      next_st.codeValid = 1'b0;
      next_st.pendB = pendSet;
      if (pendSet) begin
         next_st.pendWord = laneWord[prx_pkg::PRX_LANE_TBB];
      end
      if (take && rxMode == prx_pkg::PRX_MODE_TEN_BIT) begin
         // pins form bits 8 and 9
         next_st.code = word;
         next_st.codeValid = 1'b1;
      end else if (take && wordValid) begin
         next_st.state = prx_pkg::PRX_ST_RECV;
         next_st.errSticky = st.errSticky | wordError;
         case (rxMode)
            prx_pkg::PRX_MODE_MII: begin
               next_st.shift = {word[3:0], st.shift[7:4]};
               if (st.count == prx_pkg::PRX_MII_LAST) begin
                  next_st.count = prx_pkg::PRX_COUNT_RST;
                  next_st.data = {word[3:0], st.shift[7:4]};
                  next_st.valid = 1'b1;
                  next_st.error = st.errSticky | wordError;
                  next_st.errSticky = 1'b0;
               end else begin
                  next_st.count = 2'(st.count + 2'h1);
               end
            end
            prx_pkg::PRX_MODE_RMII: begin
               next_st.shift = {word[1:0], st.shift[7:2]};
               if (st.count == prx_pkg::PRX_RMII_LAST) begin
                  next_st.count = prx_pkg::PRX_COUNT_RST;
                  next_st.data = {word[1:0], st.shift[7:2]};
                  next_st.valid = 1'b1;
                  next_st.error = st.errSticky | wordError;
                  next_st.errSticky = 1'b0;
               end else begin
                  next_st.count = 2'(st.count + 2'h1);
               end
            end
            default: begin
               next_st.data = word[7:0];
               next_st.valid = 1'b1;
               next_st.error = wordError;
               next_st.errSticky = 1'b0;
            end
         endcase
      end else if (take) begin
         // Valid low: a partial byte is dropped at the frame end
         if (st.state == prx_pkg::PRX_ST_RECV) begin
            next_st.frameEnd = 1'b1;
         end
         next_st.state = prx_pkg::PRX_ST_IDLE;
         next_st.count = prx_pkg::PRX_COUNT_RST;
         next_st.errSticky = 1'b0;
         case (rxMode)
            prx_pkg::PRX_MODE_MII:
               next_st.falseCarrier = wordError &&
                  word[3:0] == prx_pkg::PRX_FC_NIBBLE;
            prx_pkg::PRX_MODE_GMII:
               next_st.falseCarrier = wordError &&
                  word[7:0] == prx_pkg::PRX_FC_BYTE;
            default:
               next_st.falseCarrier = 1'b0;
         endcase
      end
   end

   // Synchronous reset clears everything, including synchronisers
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign rxData = st.data;
   assign rxDataValid = st.valid;
   assign rxDataError = st.error;
   assign rxFrameEnd = st.frameEnd;
   assign rxFalseCarrier = st.falseCarrier;
   assign rxCodeGroup = st.code;
   assign rxCodeValid = st.codeValid;
   assign rxCollision = st.collision;
   assign rxInFrame = (st.state == prx_pkg::PRX_ST_RECV);

   // Checks on the core clock
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   mii_nibble_pair_a: assert property (
      rxMode == prx_pkg::PRX_MODE_MII && $past(rxMode) == rxMode && rxDataValid
      |-> $past(st.count) == prx_pkg::PRX_MII_LAST && $past(take))
      else $error("MII byte without a nibble pair");

   rmii_dibit_four_a: assert property (
      rxMode == prx_pkg::PRX_MODE_RMII && $past(rxMode) == rxMode
      && rxDataValid |-> $past(st.count) == prx_pkg::PRX_RMII_LAST)
      else $error("RMII byte without four dibits");

   gmii_full_byte_a: assert property (
      rxMode == prx_pkg::PRX_MODE_GMII && take && wordValid
      |=> rxDataValid && rxData == $past(word[7:0]))
      else $error("GMII byte not passed whole");

   ten_bit_code_a: assert property (
      rxMode == prx_pkg::PRX_MODE_TEN_BIT && take
      |=> rxCodeValid && rxCodeGroup == $past(word) && !rxDataValid)
      else $error("Code group not passed with pins 8 and 9");

   ten_bit_order_a: assert property (
      rxMode == prx_pkg::PRX_MODE_TEN_BIT && !st.pendB
      && laneEdge[prx_pkg::PRX_LANE_TBA] && laneEdge[prx_pkg::PRX_LANE_TBB]
      |-> ##2 rxCodeValid
      && rxCodeGroup == $past(laneWord[prx_pkg::PRX_LANE_TBB], 2))
      else $error("Second byte clock word not emitted after first");

   duplex_collision_a: assert property (
      fullDuplex [*2] |=> !rxCollision)
      else $error("Collision shown in full duplex");

   valid_frame_end_a: assert property (
      rxMode != prx_pkg::PRX_MODE_TEN_BIT && rxInFrame && take && !wordValid
      |=> rxFrameEnd && !rxDataValid ##1 !rxFrameEnd)
      else $error("Frame end not flagged once on valid fall");

   false_carrier_a: assert property (
      rxMode == prx_pkg::PRX_MODE_GMII && take && !wordValid && wordError
      && word[7:0] == prx_pkg::PRX_FC_BYTE |=> rxFalseCarrier && !rxInFrame)
      else $error("False carrier not flagged");

   data_error_a: assert property (
      rxMode == prx_pkg::PRX_MODE_GMII && take && wordValid && wordError
      |=> rxDataValid && rxDataError)
      else $error("Receive error lost on data byte");

   mii_byte_c: cover property (
      rxMode == prx_pkg::PRX_MODE_MII && rxDataValid);
   rmii_byte_c: cover property (
      rxMode == prx_pkg::PRX_MODE_RMII && rxDataValid ##[1:80] rxFrameEnd);
   ten_bit_pair_c: cover property (
      rxMode == prx_pkg::PRX_MODE_TEN_BIT && rxCodeValid ##[1:10] rxCodeValid);
   false_carrier_c: cover property (rxFalseCarrier);

endmodule

//--- prx_phy_model.sv
// Behavioural link partner driving the receive pins of one port
`timescale 1ns/1ps
module prx_phy_model (
   output logic rxClk,
   output logic refClk,
   output logic clkA,
   output logic clkB,
   output logic [7:0] bus,
   output logic valid,
   output logic err,
   output logic col
);
   // Clocks stand still between frames, pins idle
   initial begin
      {rxClk, refClk, clkA, clkB, valid, err, col} = 7'h00;
      bus = 8'hA5;
   end

   // collision level from the far end
   task automatic setCol(input logic v);
      col = v;
   endtask

   // one word per edge; bus goes stale after the fall
   task automatic send(input int lane, input logic [9:0] w);
      {err, valid, bus} = w;
      #16;
      if (lane == 0) rxClk = 1'b1;
      else refClk = 1'b1;
      #32;
      {rxClk, refClk} = 2'h0;
      bus = ~bus;
      #16;
   endtask

   // byte clocks antiphase; pins carry code bits 9 and 8
   task automatic pair(input logic [9:0] wa, input logic [9:0] wb);
      {err, valid, bus} = wa;
      #16;
      clkA = 1'b1;
      clkB = 1'b0;
      #16;
      {err, valid, bus} = wb;
      #16;
      clkA = 1'b0;
      clkB = 1'b1;
      // Invert the bus after the B edge so the word goes stale before the next pair
      #8;
      bus = ~bus;
      #8;
   endtask

   // idle edges on every lane so lane resets settle
   task automatic idle(input int n);
      {err, valid} = 2'h0;
      repeat (n) begin
         #16;
         {rxClk, refClk, clkA, clkB} = 4'hE;
         #32;
         {rxClk, refClk, clkA, clkB} = 4'h1;
         #8;
         bus = ~bus;
         #8;
      end
   endtask
endmodule

//--- prx_receive_port_bench.sv
// Self-checking bench for the packet port receive interface
`timescale 1ns/1ps
module prx_receive_port_bench;
   logic core_clk;
   logic reset_n;
   prx_pkg::prx_mode_e rxMode;
   logic fullDuplex;
   logic rxClk, refClk, clkA, clkB, valid, err, col;
   logic [7:0] bus;
   logic [7:0] rxData;
   logic rxDataValid, rxDataError, rxFrameEnd, rxFalseCarrier;
   logic [9:0] rxCodeGroup;
   logic rxCodeValid, rxCollision, rxInFrame;
   logic sawFrame = 1'b0;
   int failures, tests_run, evCount, fcCount, endCount;
   logic [9:0] seenQ[$];

   prx_receive_port i_dut (.core_clk(core_clk), .reset_n(reset_n),
      .rxMode(rxMode), .fullDuplex(fullDuplex),
      .portReceiveClock(rxClk), .portReferenceClock(refClk),
      .tbiByteClockA(clkA), .tbiByteClockB(clkB),
      .portReceiveBus(bus), .portReceiveValid(valid),
      .portReceiveError(err), .portCollisionIn(col),
      .rxData(rxData), .rxDataValid(rxDataValid),
      .rxDataError(rxDataError), .rxFrameEnd(rxFrameEnd),
      .rxFalseCarrier(rxFalseCarrier), .rxCodeGroup(rxCodeGroup),
      .rxCodeValid(rxCodeValid), .rxCollision(rxCollision),
      .rxInFrame(rxInFrame));

   prx_phy_model i_phy (.rxClk(rxClk), .refClk(refClk), .clkA(clkA),
      .clkB(clkB), .bus(bus), .valid(valid), .err(err), .col(col));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Pulses are collected off the launching edge, once settled
   always @(negedge core_clk) begin
      if (rxDataValid === 1'b1) seenQ.push_back({1'b0, rxDataError, rxData});
      if (rxCodeValid === 1'b1) seenQ.push_back(rxCodeGroup);
      if (rxFrameEnd === 1'b1) endCount++;
      if (rxFalseCarrier === 1'b1) fcCount++;
      if (rxInFrame === 1'b1) sawFrame = 1'b1;
      evCount += int'(rxDataValid === 1'b1) + int'(rxCodeValid === 1'b1)
         + int'(rxFrameEnd === 1'b1) + int'(rxFalseCarrier === 1'b1);
   end

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [9:0] pop();
      if (seenQ.size() == 0) return 10'hXXX;
      return seenQ.pop_front();
   endfunction

   // Bounded wait for a number of output pulses
   task automatic waitEv(input int target);
      int n;
      n = 0;
      while (evCount < target && n < 400) begin
         @(negedge core_clk);
         n++;
      end
      if (evCount < target) begin
         failures++;
         finish_test();
      end
   endtask

   task automatic setMode(input prx_pkg::prx_mode_e m);
      @(negedge core_clk);
      rxMode = m;
      repeat (2) @(negedge core_clk);
   endtask

   // Nibbles with junk upper bits, error in byte two, then false carrier
   task automatic mii_frame();
      int t;
      t = evCount + 4;
      setMode(prx_pkg::PRX_MODE_MII);
      i_phy.send(0, 10'h1F5);
      i_phy.send(0, 10'h1FA);
      i_phy.send(0, 10'h3F3);
      i_phy.send(0, 10'h1FC);
      i_phy.send(0, 10'h0F0);
      i_phy.send(0, 10'h2FE);
      waitEv(t);
      check(pop(), 10'h0A5);
      check(pop(), 10'h1C3);
      check(10'(endCount), 10'h001);
      check(10'(fcCount), 10'h001);
      check({9'h000, sawFrame}, 10'h001);
      check({9'h000, rxInFrame}, 10'h000);
   endtask

   // Four dibits on the reference clock, junk above bit 1
   task automatic rmii_frame();
      int t;
      t = evCount + 2;
      setMode(prx_pkg::PRX_MODE_RMII);
      i_phy.send(1, 10'h1FD);
      i_phy.send(1, 10'h1FE);
      i_phy.send(1, 10'h1FF);
      i_phy.send(1, 10'h1FC);
      i_phy.send(1, 10'h0FC);
      waitEv(t);
      check(pop(), 10'h039);
      check(10'(endCount), 10'h002);
   endtask

   // Full bytes, the second with error, frame end, then a false carrier
   task automatic gmii_frame();
      int t;
      t = evCount + 4;
      setMode(prx_pkg::PRX_MODE_GMII);
      i_phy.send(0, 10'h181);
      i_phy.send(0, 10'h37E);
      i_phy.send(0, 10'h000);
      i_phy.send(0, 10'h20E);
      waitEv(t);
      check(pop(), 10'h081);
      check(pop(), 10'h17E);
      check(10'(fcCount), 10'h002);
   endtask

   // Code groups on both byte clocks, valid and error pins as bits 8, 9
   task automatic tbi_words();
      int t;
      t = evCount + 4;
      setMode(prx_pkg::PRX_MODE_TEN_BIT);
      i_phy.pair(10'h2A5, 10'h1C3);
      i_phy.pair(10'h35A, 10'h03C);
      waitEv(t);
      check(pop(), 10'h2A5);
      check(pop(), 10'h1C3);
      check(pop(), 10'h35A);
      check(pop(), 10'h03C);
   endtask

   // Collision shows in half duplex only
   task automatic collision();
      @(negedge core_clk);
      fullDuplex = 1'b0;
      i_phy.setCol(1'b1);
      repeat (5) @(negedge core_clk);
      check({9'h000, rxCollision}, 10'h001);
      fullDuplex = 1'b1;
      repeat (2) @(negedge core_clk);
      check({9'h000, rxCollision}, 10'h000);
      i_phy.setCol(1'b0);
   endtask

   // Reset spans enough edges of every lane clock
   initial begin
      reset_n = 1'b0;
      rxMode = prx_pkg::PRX_MODE_MII;
      fullDuplex = 1'b1;
      fork
         i_phy.idle(4);
         repeat (20) @(negedge core_clk);
      join
      @(negedge core_clk);
      reset_n = 1'b1;
      i_phy.idle(4);
      mii_frame();
      rmii_frame();
      gmii_frame();
      tbi_words();
      collision();
      finish_test();
   end
endmodule
